// ---- include/csh_pkg.sv ----
// Purpose: shared constants and types for the configuration status handshake
// Assumes: 200 MHz reference clock
// Notes:   mode-select encodings and default counts live here
package csh_pkg;

    // reference clock cycles spent clearing configuration memory
    localparam int CLEAR_CYCLES_DEF = 64;
    // reference cycles per half period of the generated config clock
    localparam int CLK_HALF_DEF = 4;

    // mode-select pin encodings
    localparam logic [2:0] MODE_MASTER_SERIAL   = 3'h0;
    localparam logic [2:0] MODE_SERIAL_FLASH    = 3'h1;
    localparam logic [2:0] MODE_PARALLEL_FLASH  = 3'h2;
    localparam logic [2:0] MODE_MASTER_PARALLEL = 3'h4;
    localparam logic [2:0] MODE_TEST_PORT       = 3'h5;
    localparam logic [2:0] MODE_SLAVE_PARALLEL  = 3'h6;
    localparam logic [2:0] MODE_SLAVE_SERIAL    = 3'h7;

    // synchroniser value after reset: restart asserted, init line low
    localparam logic [1:0] SYNC_RESET_VAL = 2'h0;

    typedef enum logic [2:0]
    {
        ST_RESET,
        ST_CLEAR,
        ST_WAIT_INIT,
        ST_LOAD,
        ST_DONE,
        ST_ERROR
    } csh_state_type;

    // true for modes in which the device sources the config clock
    function automatic logic is_master(input logic [2:0] mode);
        is_master = (mode == MODE_MASTER_SERIAL) || (mode == MODE_SERIAL_FLASH)
                 || (mode == MODE_PARALLEL_FLASH) || (mode == MODE_MASTER_PARALLEL);
    endfunction

endpackage

// ---- hdl/csh_sync.sv ----
// Purpose: two-flop synchroniser for external status pins
// Assumes: one clock, synchronous active-low reset
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module csh_sync #(
    parameter int         WIDTH     = 2,
    parameter logic [1:0] RESET_VAL = csh_pkg::SYNC_RESET_VAL
)(
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_clk_en,
    // pins in, synchronised levels out
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } csh_sync_type;

    csh_sync_type r;
    csh_sync_type next_r;

    generate
        if (WIDTH < 1)
        begin : g_bad_width
            $error("csh_sync: width must be at least one");
        end
    endgenerate

    always_comb
    begin
        next_r = r;
        if (i_clk_en)
        begin
            next_r.stage1 = i_async;
            next_r.stage2 = r.stage1;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            r.stage1 <= WIDTH'(RESET_VAL);
            r.stage2 <= WIDTH'(RESET_VAL);
        end
        else
        begin
            r <= next_r;
        end
    end

    assign o_sync = r.stage2;

endmodule

// ---- hdl/csh_config_status.sv ----
// Purpose: init, done and config clock handshake of the configuration loader
// Assumes: 200 MHz i_ref_clk, synchronous active-low reset, open-drain pads outside
// Notes:   steps advance on the config clock, generated or received
//
// Functional notes
// - init driven low in reset, clear, error
// - release init after memory clear finishes
// - hold in wait while init held low
// - init high proceeds, mode from pins
// - optionally flag error on init after done
// - release done line when sequence completes
// - master modes drive config clock out
// - every step advances on config clock
// - restart low resets, rising edge restarts
`timescale 1ns/1ps
module csh_config_status #(
    parameter int CLEAR_CYCLES = csh_pkg::CLEAR_CYCLES_DEF,
    parameter int CLK_HALF     = csh_pkg::CLK_HALF_DEF
)(
    // clock, reset, enable
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_clk_en,
    // external status pins
    input  wire logic       i_restart_n,
    input  wire logic       i_init_in,
    input  wire logic [2:0] i_mode,
    input  wire logic       i_config_clock_in,
    // loader side
    input  wire logic       i_load_done,
    input  wire logic       i_cfg_error,
    input  wire logic       i_err_report_en,
    // open-drain init line
    output logic            o_init_out,
    output logic            o_init_oe,
    // open-drain done line
    output logic            o_done_out,
    output logic            o_done_oe,
    // config clock pin
    output logic            o_config_clock_out,
    output logic            o_config_clock_oe,
    // status
    output logic            o_step,
    output logic [2:0]      o_mode
);

    ////////////////////////////////////////////////////////////////////////////////
    localparam int CNT_W = $clog2(CLEAR_CYCLES + 1);
    localparam int DIV_W = $clog2(CLK_HALF + 1);

    generate
        if (CLEAR_CYCLES < 1 || CLK_HALF < 1)
        begin : g_bad_param
            $error("csh_config_status: counts must be at least one");
        end
    endgenerate

    typedef struct packed {
        csh_pkg::csh_state_type st;
        logic [CNT_W-1:0]       cnt;
        logic [DIV_W-1:0]       div;
        logic                   config_clock;
        logic                   config_clock_oe;
        logic                   cin_q;
        logic                   init_drive;
        logic                   done_drive;
        logic                   step;
        logic [2:0]             mode;
    } csh_regs_type;

    csh_regs_type r;
    csh_regs_type next_r;
    logic [1:0]   sync_out;
    logic         restart_s;
    logic         init_s;
    logic         tick;
    logic         master_rise;
    logic         slave_rise;

    ////////////////////////////////////////////////////////////////////////////////
    // pins from the board are not related to our clock
    csh_sync #(
        .WIDTH     (2),
        .RESET_VAL (csh_pkg::SYNC_RESET_VAL)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_clk_en  (i_clk_en),
        .i_async   ({i_restart_n, i_init_in}),
        .o_sync    (sync_out)
    );

    assign restart_s = sync_out[1];
    assign init_s    = sync_out[0];

    ////////////////////////////////////////////////////////////////////////////////
    // config clock: own divider in master modes, sampled pin otherwise
    assign master_rise = r.config_clock_oe && !r.config_clock && (r.div == DIV_W'(CLK_HALF - 1));
    assign slave_rise  = i_config_clock_in && !r.cin_q;
    assign tick        = csh_pkg::is_master(r.mode) ? master_rise : slave_rise;

    always_comb
    begin
        next_r = r;
        if (i_clk_en)
        begin
            next_r.step  = 1'b0;
            next_r.cin_q = i_config_clock_in;
            if (r.config_clock_oe)
            begin
                if (r.div == DIV_W'(CLK_HALF - 1))
                begin
                    next_r.div  = '0;
                    next_r.config_clock = ~r.config_clock;
                end
                else
                begin
                    next_r.div = r.div + DIV_W'(1);
                end
            end
            unique case (r.st)
                csh_pkg::ST_RESET:
                begin
                    // rising edge of restart starts a new sequence
                    if (restart_s)
                    begin
                        next_r.st  = csh_pkg::ST_CLEAR;
                        next_r.cnt = '0;
                    end
                end
                csh_pkg::ST_CLEAR:
                begin
                    if (r.cnt == CNT_W'(CLEAR_CYCLES - 1))
                    begin
                        next_r.st         = csh_pkg::ST_WAIT_INIT;
                        next_r.init_drive = 1'b0;
                    end
                    else
                    begin
                        next_r.cnt = r.cnt + CNT_W'(1);
                    end
                end
                csh_pkg::ST_WAIT_INIT:
                begin
                    // a partner holding init low stalls us here
                    if (init_s)
                    begin
                        next_r.st      = csh_pkg::ST_LOAD;
                        next_r.mode    = i_mode;
                        next_r.config_clock_oe = csh_pkg::is_master(i_mode);
                        next_r.div     = '0;
                        next_r.config_clock    = 1'b0;
                    end
                end
                csh_pkg::ST_LOAD:
                begin
                    if (tick)
                    begin
                        next_r.step = 1'b1;
                        if (i_cfg_error)
                        begin
                            next_r.st         = csh_pkg::ST_ERROR;
                            next_r.init_drive = 1'b1;
                        end
                        else if (i_load_done)
                        begin
                            next_r.st         = csh_pkg::ST_DONE;
                            next_r.done_drive = 1'b0;
                        end
                    end
                end
                csh_pkg::ST_DONE:
                begin
                    // sticky until restart; software may leave reporting off
                    if (i_err_report_en && i_cfg_error)
                    begin
                        next_r.init_drive = 1'b1;
                    end
                end
                csh_pkg::ST_ERROR:
                begin
                    next_r.init_drive = 1'b1;
                end
                default:
                begin
                    next_r.st = csh_pkg::ST_RESET;
                end
            endcase
            // restart low wins over everything, held until it rises
            if (!restart_s)
            begin
                next_r.st         = csh_pkg::ST_RESET;
                next_r.init_drive = 1'b1;
                next_r.done_drive = 1'b1;
                next_r.config_clock_oe    = 1'b0;
                next_r.config_clock       = 1'b0;
                next_r.step       = 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            r.st         <= csh_pkg::ST_RESET;
            r.cnt        <= '0;
            r.div        <= '0;
            r.config_clock       <= 1'b0;
            r.config_clock_oe    <= 1'b0;
            r.cin_q      <= 1'b0;
            r.init_drive <= 1'b1;
            r.done_drive <= 1'b1;
            r.step       <= 1'b0;
            r.mode       <= csh_pkg::MODE_SLAVE_SERIAL;
        end
        else
        begin
            r <= next_r;
        end
    end

    // open-drain lines only ever pull low
    assign o_init_out         = 1'b0;
    assign o_init_oe          = r.init_drive;
    assign o_done_out         = 1'b0;
    assign o_done_oe          = r.done_drive;
    assign o_config_clock_out = r.config_clock;
    assign o_config_clock_oe  = r.config_clock_oe;
    assign o_step             = r.step;
    assign o_mode             = r.mode;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_live;
        i_clk_en && restart_s;
    endsequence

    sequence s_restart_held;
        (!i_restart_n && i_clk_en) ##1 (!i_restart_n && i_clk_en) ##1 i_clk_en;
    endsequence

    chk_init_low_reset: assert property (
        (!restart_s && i_clk_en) |=> (o_init_oe && r.st == csh_pkg::ST_RESET))
        else $error("init not driven low during restart");

    chk_init_release: assert property (
        (s_live ##0 (r.st == csh_pkg::ST_CLEAR && r.cnt == CNT_W'(CLEAR_CYCLES - 1)))
        |=> (!o_init_oe && r.st == csh_pkg::ST_WAIT_INIT))
        else $error("init not released after clearing");

    chk_init_stall: assert property (
        (r.st == csh_pkg::ST_WAIT_INIT && !init_s)
        |=> (r.st == csh_pkg::ST_WAIT_INIT || r.st == csh_pkg::ST_RESET))
        else $error("sequence left wait while init held low");

    chk_init_proceed: assert property (
        (s_live ##0 (r.st == csh_pkg::ST_WAIT_INIT && init_s))
        |=> (r.st == csh_pkg::ST_LOAD && o_mode == $past(i_mode)))
        else $error("init high did not start loading with pin mode");

    chk_error_flag: assert property (
        (s_live ##0 (r.st == csh_pkg::ST_DONE && i_err_report_en && i_cfg_error))
        |=> (o_init_oe && r.st == csh_pkg::ST_DONE))
        else $error("error after done not flagged on init");

    chk_done_release: assert property (
        (s_live ##0 (r.st == csh_pkg::ST_LOAD && tick && i_load_done && !i_cfg_error))
        |=> (!o_done_oe ##1 (!o_done_oe || !$past(restart_s))))
        else $error("done line not released on completion");

    chk_clock_drive: assert property (
        (r.st == csh_pkg::ST_LOAD) |-> (o_config_clock_oe == csh_pkg::is_master(o_mode)))
        else $error("config clock drive does not match mode");

    chk_step_tick: assert property (
        (s_live ##0 (r.st == csh_pkg::ST_LOAD)) |=> (o_step == $past(tick)))
        else $error("step not tied to config clock edge");

    chk_restart_new: assert property (
        (s_live ##0 (r.st == csh_pkg::ST_RESET)) |=> (r.st == csh_pkg::ST_CLEAR && r.cnt == '0))
        else $error("restart release did not begin clearing");

    chk_sync_restart: assert property (
        s_restart_held |=> (o_init_oe && !o_done_oe == 1'b0))
        else $error("synchronised restart did not reset the loader");

endmodule

// ---- sim/csh_board_model.sv ----
// Purpose: board-side partner of the config status handshake
// Assumes: pull-ups on init and done, bench commands stall and slave clock
// Notes:   slave clock stands still at 0 while not running
`timescale 1ns/1ps
module csh_board_model #(
    parameter int IGNORE_CYCLES = 32,
    parameter int SLAVE_HALF    = 3
)(
    // clock
    input  wire logic i_ref_clk,
    // device pad controls
    input  wire logic i_init_oe,
    input  wire logic i_done_oe,
    input  wire logic i_clk_oe,
    input  wire logic i_clk_out,
    // bench commands
    input  wire logic i_hold_init,
    input  wire logic i_slave_run,
    // resolved lines
    output logic      o_init_level,
    output logic      o_done_level,
    output logic      o_config_clock,
    output logic      o_cfg_ok
);
    int   por_cnt   = 0;
    int   half_cnt  = 0;
    logic slave_clk = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // open-drain lines read high only when nobody pulls
    assign o_init_level   = !(i_init_oe || i_hold_init);
    assign o_done_level   = !i_done_oe;
    assign o_config_clock = i_clk_oe ? i_clk_out : slave_clk;
    // early highs after power-on are not trusted
    assign o_cfg_ok = (por_cnt >= IGNORE_CYCLES) && o_init_level && o_done_level;

    always @(posedge i_ref_clk)
    begin
        if (por_cnt < IGNORE_CYCLES)
            por_cnt <= por_cnt + 1;
        if (!i_slave_run)
        begin
            half_cnt  <= 0;
            slave_clk <= 1'b0;
        end
        else if (half_cnt == SLAVE_HALF - 1)
        begin
            half_cnt  <= 0;
            slave_clk <= ~slave_clk;
        end
        else
            half_cnt <= half_cnt + 1;
    end
endmodule

// ---- sim/tb_config_status_handshake_pins.sv ----
// Purpose: self-checking bench for the config status handshake
// Assumes: short clear and clock-divide counts for a quick run
// Notes:   mode table walks every clock-sourcing choice
`timescale 1ns/1ps
module tb_config_status_handshake_pins;
    localparam int CLEAR_N = 4;
    localparam int HALF_N  = 2;
    localparam int SLV_H   = 3;

    logic       i_ref_clk = 1'b0;
    logic       i_rst_n   = 1'b0;
    logic       clk_en    = 1'b1;
    logic       restart_n = 1'b1;
    logic       load_done = 1'b0;
    logic       cfg_error = 1'b0;
    logic       err_rep   = 1'b0;
    logic       hold_init = 1'b0;
    logic       slave_run = 1'b0;
    logic [2:0] mode      = 3'h0;
    wire logic  init_level, done_level, config_clock, cfg_ok;
    wire logic  init_out, init_oe, done_out, done_oe, clk_out, clk_oe, step;
    wire logic [2:0] o_mode;
    int         failures  = 0;
    int         tests_run = 0;
    int         cycles    = 0;

    ////////////////////////////////////////////////////////////////////////////
    csh_config_status #(.CLEAR_CYCLES(CLEAR_N), .CLK_HALF(HALF_N)) csh_config_status_i (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(clk_en),
        .i_restart_n(restart_n), .i_init_in(init_level), .i_mode(mode),
        .i_config_clock_in(config_clock), .i_load_done(load_done), .i_cfg_error(cfg_error),
        .i_err_report_en(err_rep), .o_init_out(init_out), .o_init_oe(init_oe),
        .o_done_out(done_out), .o_done_oe(done_oe), .o_config_clock_out(clk_out),
        .o_config_clock_oe(clk_oe), .o_step(step), .o_mode(o_mode));

    csh_board_model #(.IGNORE_CYCLES(32), .SLAVE_HALF(SLV_H)) csh_board_model_i (
        .i_ref_clk(i_ref_clk), .i_init_oe(init_oe), .i_done_oe(done_oe),
        .i_clk_oe(clk_oe), .i_clk_out(clk_out), .i_hold_init(hold_init),
        .i_slave_run(slave_run), .o_init_level(init_level), .o_done_level(done_level),
        .o_config_clock(config_clock), .o_cfg_ok(cfg_ok));

    always #2.5 i_ref_clk = ~i_ref_clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check_val(input logic [2:0] got, input logic [2:0] exp, input string msg);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask

    task automatic check_cnt(input int got, input int exp, input string msg);
        tests_run++;
        if (got != exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask

    // look just after the edge so registered outputs have landed
    task automatic settle;
        @(posedge i_ref_clk);
        #1;
    endtask

    task automatic finish_test;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // restart pulse with the board stalling init, then time the clear
    task automatic do_restart;
        int n;
        @(posedge i_ref_clk) restart_n <= 1'b0;
        hold_init <= 1'b1;
        repeat (4) settle();
        check_val(init_oe, 1'b1, "init not pulled in restart");
        check_val(done_oe, 1'b1, "done not pulled in restart");
        check_val(clk_oe, 1'b0, "clock driven in restart");
        @(posedge i_ref_clk) restart_n <= 1'b1;
        n = 0;
        do begin settle(); n++; end while (init_oe !== 1'b0 && n < 200);
        check_cnt(n, 3 + CLEAR_N, "init release time");
    endtask

    // err_after: 0 none, 1 flagged after done, 2 unflagged, 3 error in load
    task automatic run_mode(input logic [2:0] m, input logic master, input int err_after);
        int n;
        int gap;
        do_restart();
        @(posedge i_ref_clk) mode <= m;
        repeat (20) settle();
        check_val(clk_oe, 1'b0, "clock driven while stalled");
        check_val(done_oe, 1'b1, "done released while stalled");
        check_val(init_oe, 1'b0, "init pulled while stalled");
        // enable low must freeze the synchronisers and the wait state
        @(posedge i_ref_clk) clk_en <= 1'b0;
        hold_init <= 1'b0;
        repeat (8) settle();
        check_val(clk_oe, 1'b0, "loader moved while enable low");
        check_val(init_oe, 1'b0, "init pulled while enable low");
        @(posedge i_ref_clk) clk_en <= 1'b1;
        repeat (3) settle();
        check_val(o_mode, m, "mode not latched");
        check_val(clk_oe, master, "clock drive enable");
        @(posedge i_ref_clk) slave_run <= !master;
        n = 0;
        do begin settle(); n++; end while (step !== 1'b1 && n < 100);
        check_val(step, 1'b1, "no step seen");
        check_val(config_clock, 1'b1, "config clock not high at step");
        gap = 0;
        do begin settle(); gap++; end while (step !== 1'b1 && gap < 100);
        check_cnt(gap, master ? 2 * HALF_N : 2 * SLV_H, "step spacing");
        if (err_after == 3)
        begin
            @(posedge i_ref_clk) cfg_error <= 1'b1;
            n = 0;
            do begin settle(); n++; end while (init_oe !== 1'b1 && n < 40);
            check_val(init_oe, 1'b1, "error not flagged");
            check_val(done_oe, 1'b1, "done after error");
        end
        else
        begin
            @(posedge i_ref_clk) load_done <= 1'b1;
            n = 0;
            do begin settle(); n++; end while (done_oe !== 1'b0 && n < 40);
            check_val(step, 1'b1, "done off a step");
            check_val(cfg_ok, 1'b1, "board does not see done");
            @(posedge i_ref_clk) load_done <= 1'b0;
            err_rep   <= (err_after == 1);
            cfg_error <= (err_after != 0);
            repeat (2) settle();
            check_val(init_oe, (err_after == 1), "error flag after done");
            check_val(done_oe, 1'b0, "done lost");
        end
        @(posedge i_ref_clk) cfg_error <= 1'b0;
        slave_run <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge i_ref_clk)
    begin
        cycles++;
        // whole run needs well under this
        if (cycles == 20000)
        begin
            failures++;
            finish_test();
        end
    end

    initial
    begin
        repeat (16) settle();
        check_val(init_oe, 1'b1, "init in reset");
        check_val(done_oe, 1'b1, "done in reset");
        check_val(clk_oe, 1'b0, "clock in reset");
        check_val(o_mode, 3'h7, "mode in reset");
        check_val(init_out, 1'b0, "init data not low");
        check_val(done_out, 1'b0, "done data not low");
        check_val(clk_out, 1'b0, "config clock out in reset");
        @(posedge i_ref_clk) i_rst_n <= 1'b1;
        run_mode(csh_pkg::MODE_MASTER_SERIAL, 1'b1, 0);
        run_mode(csh_pkg::MODE_SERIAL_FLASH, 1'b1, 1);
        run_mode(csh_pkg::MODE_PARALLEL_FLASH, 1'b1, 2);
        run_mode(csh_pkg::MODE_MASTER_PARALLEL, 1'b1, 3);
        run_mode(csh_pkg::MODE_SLAVE_PARALLEL, 1'b0, 1);
        run_mode(csh_pkg::MODE_TEST_PORT, 1'b0, 0);
        run_mode(csh_pkg::MODE_SLAVE_SERIAL, 1'b0, 3);
        finish_test();
    end
endmodule
